// ==== rtl/dds_map.svh ====
// Register map, field positions, reset values and timing counts of the DDS control block
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH
`define DDS_CTRL_OFS       12'h000
`define DDS_FREQ_A_OFS     12'h004
`define DDS_FREQ_B_OFS     12'h008
`define DDS_PHASE_A_OFS    12'h00C
`define DDS_PHASE_B_OFS    12'h010
`define DDS_STATUS_OFS     12'h014
`define DDS_OUT_OFS        12'h018
`define DDS_CTRL_RESET_BIT 8
`define DDS_CTRL_HALT_BIT  7
`define DDS_CTRL_DACPD_BIT 6
`define DDS_CTRL_SQEN_BIT  5
`define DDS_CTRL_FSEL_BIT  11
`define DDS_CTRL_PSEL_BIT  10
`define DDS_CTRL_HALVE_BIT 3
`define DDS_CTRL_MODE_BIT  1
`define DDS_CTRL_RST_VAL   32'h0000_0100
`define DDS_RESUME_CYCLES  4'h8
`endif

// ==== rtl/dds_pkg.sv ====
// Types shared by the DDS control block
package dds_pkg;
  typedef struct packed {
    logic freq_bank_select;
    logic phase_bank_select;
    logic accum_reset;
    logic clock_halt_bit;
    logic dac_powerdown_bit;
    logic square_output_enable;
    logic square_halve_select;
    logic waveform_mode;
  } ctrl_t;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_PRIME = 2'b01,
    ST_RUN   = 2'b11
  } run_state_t;
endpackage

// ==== rtl/dds_sine_rom.sv ====
// Registered quarter-wave-folded sine lookup, 10-bit amplitude
`timescale 1ns/1ps
module dds_sine_rom (
  input  wire logic       core_clk_i,
  input  wire logic       en_i,
  input  wire logic [9:0] phase_i,
  output logic      [9:0] amp_o
);
  logic [7:0] addr;
  logic [8:0] quarter;
  logic [9:0] amp_ff;

  // Quarter table from a parabolic fit keeps the memory tiny
  function automatic logic [8:0] quarter_amp(input logic [7:0] a);
    logic [15:0] sq;
    sq = 16'(a) * 16'(a);
    // Slight upscale puts the zero crossing within two codes of midscale
    quarter_amp = 9'(511 - ((sq + (sq >> 8)) >> 7));
  endfunction

  assign addr    = phase_i[8] ? ~phase_i[7:0] : phase_i[7:0];
  assign quarter = quarter_amp(~addr);

  always_ff @(posedge core_clk_i)
  begin
    if (en_i)
      amp_ff <= phase_i[9] ? 10'(10'h200 - {1'b0, quarter}) : 10'(10'h1FF + {1'b0, quarter});
  end
  assign amp_o = amp_ff;
endmodule // dds_sine_rom

// ==== rtl/dds_output_control.sv ====
// DDS control core: accumulator, sleep, waveform select, AHB-Lite registers
// How it works
// [R01] Reset bit set clears accumulator and pipeline, output sits at midscale.
// [R02] Reset bit leaves frequency, phase and control registers untouched.
// [R03] Host sets reset bit after power-up and clears it to release.
// [R04] Generated signal reaches DAC eight clocks after reset bit clears.
// [R05] Halt bit stops internal clock, powerdown bit turns off DAC.
// [R06] Halted clock freezes accumulator and holds DAC output.
// [R07] Register writes are accepted while halted.
// [R08] Bank select bits still take effect while halted.
// [R09] Clearing halt resumes synthesis; pending changes appear after pipeline latency.
// [R10] Square enable routes DAC data MSB to output pin.
// [R11] Halve select one gives MSB directly, zero gives MSB divided by two.
// [R12] Mode zero without square enable drives sine through lookup.
// [R13] Mode one bypasses lookup, feeding 10-bit linear triangle.
// [R14] Halve select ignored when square enable is zero.
// [R15] Host keeps DAC powered when output uses sine or triangle.
// [R16] Host may power DAC down when only square output is used.
// [R17] Host loads both frequency registers and toggles bank select for FSK.
// [R18] Two selectable phase offset registers support PSK.
// [R19] Frequency bank select picks one of two 28-bit frequency registers.
// [R20] Phase bank select picks one of two 12-bit phase offsets.
// [R21] Host never sets mode and square enable together; reserved.
`timescale 1ns/1ps
`include "dds_map.svh"
module dds_output_control #(
  parameter int FREQ_W  = 28,
  parameter int PHASE_W = 12,
  parameter int DAC_W   = 10
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              hsel_i,
  input  wire logic [11:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic      [DAC_W-1:0]  dac_data_o,
  output logic                   dac_enable_o,
  output logic                   waveform_output_pin_o,
  output logic                   square_mode_o
);
  dds_pkg::ctrl_t      ctrl_ff;
  dds_pkg::run_state_t state_ff;
  dds_pkg::run_state_t nxt_state;
  logic [FREQ_W-1:0]  freq_register_a_ff;
  logic [FREQ_W-1:0]  freq_register_b_ff;
  logic [PHASE_W-1:0] phase_offset_a_ff;
  logic [PHASE_W-1:0] phase_offset_b_ff;
  logic [FREQ_W-1:0]  accum_ff;
  logic [PHASE_W-1:0] phase_ff;
  logic [3:0]         resume_cnt_ff;
  logic               halve_ff;
  logic               msb_prev_ff;
  logic [DAC_W-1:0]   dac_ff;
  logic               pin_ff;
  logic               dac_en_ff;
  logic               sq_ff;
  logic [31:0]        rdata_ff;
  logic               wr_pend_ff;
  logic [11:0]        wr_addr_ff;

  logic               addr_phase;
  logic               nco_en;
  logic [FREQ_W-1:0]  freq_sel;
  logic [PHASE_W-1:0] phase_sel;
  logic [PHASE_W-1:0] phase_sum;
  logic [DAC_W-1:0]   tri_amp;
  logic [DAC_W-1:0]   sine_amp;
  logic [DAC_W-1:0]   amp_sel;
  logic               amp_msb;
  logic               msb_rise;
  logic               nxt_pin;
  logic [31:0]        rd_mux;
  logic [31:0]        ctrl_word;
  dds_pkg::ctrl_t     ctrl_new;

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_phase  = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  assign ctrl_word = {20'h0, ctrl_ff.freq_bank_select, ctrl_ff.phase_bank_select, 1'b0,
                      ctrl_ff.accum_reset, ctrl_ff.clock_halt_bit, ctrl_ff.dac_powerdown_bit,
                      ctrl_ff.square_output_enable, 1'b0, ctrl_ff.square_halve_select,
                      1'b0, ctrl_ff.waveform_mode, 1'b0};

  assign ctrl_new.freq_bank_select     = hwdata_i[`DDS_CTRL_FSEL_BIT];
  assign ctrl_new.phase_bank_select    = hwdata_i[`DDS_CTRL_PSEL_BIT];
  assign ctrl_new.accum_reset          = hwdata_i[`DDS_CTRL_RESET_BIT];
  assign ctrl_new.clock_halt_bit       = hwdata_i[`DDS_CTRL_HALT_BIT];
  assign ctrl_new.dac_powerdown_bit    = hwdata_i[`DDS_CTRL_DACPD_BIT];
  assign ctrl_new.square_output_enable = hwdata_i[`DDS_CTRL_SQEN_BIT];
  assign ctrl_new.square_halve_select  = hwdata_i[`DDS_CTRL_HALVE_BIT];
  assign ctrl_new.waveform_mode        = hwdata_i[`DDS_CTRL_MODE_BIT];

  assign rd_mux =
    (haddr_i == `DDS_CTRL_OFS)    ? ctrl_word :
    (haddr_i == `DDS_FREQ_A_OFS)  ? 32'(freq_register_a_ff) :
    (haddr_i == `DDS_FREQ_B_OFS)  ? 32'(freq_register_b_ff) :
    (haddr_i == `DDS_PHASE_A_OFS) ? 32'(phase_offset_a_ff) :
    (haddr_i == `DDS_PHASE_B_OFS) ? 32'(phase_offset_b_ff) :
    (haddr_i == `DDS_STATUS_OFS)  ? {24'h0, 2'(state_ff), 2'h0, resume_cnt_ff} :
    (haddr_i == `DDS_OUT_OFS)     ? {20'h0, pin_ff, 1'b0, 10'(dac_ff)} :
    32'h0000_0000;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= addr_phase && hwrite_i;
      wr_addr_ff <= haddr_i;
      if (addr_phase && !hwrite_i)
        rdata_ff <= rd_mux;
    end
  end
  assign hrdata_o = rdata_ff;

  // Writes land in any sleep state; reset bit never touches these
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_ff            <= dds_pkg::ctrl_t'(8'h20);
      freq_register_a_ff <= '0;
      freq_register_b_ff <= '0;
      phase_offset_a_ff  <= '0;
      phase_offset_b_ff  <= '0;
    end
    else if (wr_pend_ff) // [R07] [R02]
    begin
      case (wr_addr_ff)
        `DDS_CTRL_OFS:    ctrl_ff <= ctrl_new;
        `DDS_FREQ_A_OFS:  freq_register_a_ff <= hwdata_i[FREQ_W-1:0];
        `DDS_FREQ_B_OFS:  freq_register_b_ff <= hwdata_i[FREQ_W-1:0];
        `DDS_PHASE_A_OFS: phase_offset_a_ff <= hwdata_i[PHASE_W-1:0];
        `DDS_PHASE_B_OFS: phase_offset_b_ff <= hwdata_i[PHASE_W-1:0];
        default:          ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Bank selects decode on the synchronizing clock, halted or not
  assign freq_sel  = ctrl_ff.freq_bank_select ? freq_register_b_ff
                                              : freq_register_a_ff; // [R19] [R17] [R08]
  assign phase_sel = ctrl_ff.phase_bank_select ? phase_offset_b_ff
                                               : phase_offset_a_ff; // [R20] [R18] [R08]

  // Halt gates the synthesis path through one enable
  assign nco_en = !ctrl_ff.clock_halt_bit; // [R05] [R06] [R09]

  // Run state: reset holds, prime counts eight cycles, run releases output
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dds_pkg::ST_RESET: nxt_state = ctrl_ff.accum_reset ? dds_pkg::ST_RESET
                                                         : dds_pkg::ST_PRIME;
      dds_pkg::ST_PRIME:
      begin
        if (ctrl_ff.accum_reset)
          nxt_state = dds_pkg::ST_RESET;
        else if (resume_cnt_ff == 4'(`DDS_RESUME_CYCLES - 4'h1) && nco_en)
          nxt_state = dds_pkg::ST_RUN;
      end
      dds_pkg::ST_RUN:   nxt_state = ctrl_ff.accum_reset ? dds_pkg::ST_RESET
                                                         : dds_pkg::ST_RUN;
      default:           nxt_state = dds_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || ctrl_ff.accum_reset)
      resume_cnt_ff <= 4'h0;
    else if (state_ff != dds_pkg::ST_RUN && nco_en)
      // Counts from the first edge with the reset bit clear
      resume_cnt_ff <= resume_cnt_ff + 4'h1; // [R04]
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state_ff <= dds_pkg::ST_RESET;
    else
      state_ff <= nxt_state;
  end

  // Accumulator path cleared by the reset bit or srst_i
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || ctrl_ff.accum_reset)
    begin
      accum_ff <= '0; // [R01]
      phase_ff <= '0;
    end
    else if (nco_en) // [R06]
    begin
      accum_ff <= accum_ff + freq_sel;
      phase_ff <= phase_sum;
    end
  end
  assign phase_sum = accum_ff[FREQ_W-1 -: PHASE_W] + phase_sel; // [R20]

  // Triangle: fold the truncated phase into an up-down ramp
  assign tri_amp = phase_ff[PHASE_W-1] ? ~phase_ff[PHASE_W-2 -: DAC_W]
                                       : phase_ff[PHASE_W-2 -: DAC_W]; // [R13]

  dds_sine_rom u_sine (
    .core_clk_i (core_clk_i),
    .en_i       (nco_en),
    .phase_i    (phase_ff[PHASE_W-1 -: DAC_W]),
    .amp_o      (sine_amp)
  );

  // Reserved mode/square combination falls to the sine path
  assign amp_sel = (ctrl_ff.waveform_mode && !ctrl_ff.square_output_enable)
                   ? tri_amp : sine_amp; // [R12] [R13] [R21]
  assign amp_msb  = amp_sel[DAC_W-1];
  assign msb_rise = amp_msb && !msb_prev_ff;

  // Divide-by-two toggles on each rising MSB edge
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || ctrl_ff.accum_reset)
    begin
      halve_ff    <= 1'b0;
      msb_prev_ff <= 1'b0;
    end
    else if (nco_en)
    begin
      msb_prev_ff <= amp_msb;
      if (msb_rise)
        halve_ff <= !halve_ff; // [R11]
    end
  end

  // Square pin ignores halve select unless square output enabled
  assign nxt_pin = !ctrl_ff.square_output_enable ? 1'b0 :
                   ctrl_ff.square_halve_select ? amp_msb : halve_ff; // [R10] [R11] [R14]

  // Outputs: midscale until eight cycles after reset releases
  always_ff @(posedge core_clk_i)
  begin
    // Next state opens the output on the eighth edge, not one later
    if (srst_i || nxt_state != dds_pkg::ST_RUN)
    begin
      dac_ff <= 10'h200; // [R01] [R04]
      pin_ff <= 1'b0;
    end
    else if (nco_en) // [R06]
    begin
      dac_ff <= amp_sel;
      pin_ff <= nxt_pin;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      dac_en_ff <= 1'b1;
      sq_ff     <= 1'b0;
    end
    else
    begin
      dac_en_ff <= !ctrl_ff.dac_powerdown_bit; // [R05] [R15] [R16]
      sq_ff     <= ctrl_ff.square_output_enable;
    end
  end

  assign dac_data_o            = dac_ff;
  assign dac_enable_o          = dac_en_ff;
  assign waveform_output_pin_o = pin_ff;
  assign square_mode_o         = sq_ff;
endmodule // dds_output_control

// ==== verif/dds_output_control_sva.sv ====
// Port assertions for the DDS control block, bound to the design top
`timescale 1ns/1ps
`include "dds_map.svh"
module dds_ctrl_chk #(
  parameter int DAC_W = 10
) (
  input wire logic             core_clk_i,
  input wire logic             srst_i,
  input wire logic             hsel_i,
  input wire logic [11:0]      haddr_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic [31:0]      hwdata_i,
  input wire logic             hready_i,
  input wire logic [31:0]      hrdata_o,
  input wire logic             hreadyout_o,
  input wire logic             hresp_o,
  input wire logic [DAC_W-1:0] dac_data_o,
  input wire logic             dac_enable_o,
  input wire logic             waveform_output_pin_o,
  input wire logic             square_mode_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  logic        wr_ctl_ff;
  logic [31:0] ctl_ff;
  wire         take   = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  wire         rst_b  = ctl_ff[`DDS_CTRL_RESET_BIT];
  wire         halt_b = ctl_ff[`DDS_CTRL_HALT_BIT];
  wire         sq_b   = ctl_ff[`DDS_CTRL_SQEN_BIT];
  // Shadow of the control word, loaded on the write data edge
  always_ff @(posedge core_clk_i)
  begin
    wr_ctl_ff <= ~srst_i & hsel_i & htrans_i[1] & hwrite_i & (haddr_i == `DDS_CTRL_OFS);
    if (srst_i)
      ctl_ff <= `DDS_CTRL_RST_VAL;
    else if (wr_ctl_ff)
      ctl_ff <= hwdata_i;
  end
  ready_high_a: assert property (hreadyout_o) else $error("wait state seen");
  resp_okay_a: assert property (!hresp_o) else $error("error response seen");
  reset_mid_a: assert property ((rst_b & !halt_b) [*3] |-> dac_data_o == 10'h200)
    else $error("not midscale in reset");
  resume_wait_a: assert property ($fell(rst_b) |-> (dac_data_o == 10'h200) [*7])
    else $error("output before resume delay");
  halt_hold_a: assert property ((halt_b & !rst_b) [*2] |=> $stable(dac_data_o)
    && $stable(waveform_output_pin_o)) else $error("output moved while halted");
  dac_power_a: assert property (dac_enable_o == !$past(ctl_ff[`DDS_CTRL_DACPD_BIT]))
    else $error("dac enable wrong");
  sq_flag_a: assert property (square_mode_o == $past(sq_b)) else $error("square flag wrong");
  pin_idle_a: assert property ((!sq_b & !halt_b) [*3] |-> !waveform_output_pin_o)
    else $error("pin active outside square mode");
  ctl_read_a: assert property (take && haddr_i == `DDS_CTRL_OFS |=> (hrdata_o & 32'h0DEA) ==
    ($past(ctl_ff) & 32'h0DEA)) else $error("control readback wrong");
  gap_read_a: assert property (take && haddr_i > `DDS_OUT_OFS |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  cover property ($fell(rst_b));
  cover property (halt_b [*4]);
  cover property (sq_b && waveform_output_pin_o);
endmodule // dds_ctrl_chk

bind dds_output_control dds_ctrl_chk #(.DAC_W(DAC_W)) chk_u (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .dac_data_o(dac_data_o), .dac_enable_o(dac_enable_o),
  .waveform_output_pin_o(waveform_output_pin_o), .square_mode_o(square_mode_o));

// ==== verif/dds_host_model.sv ====
// Host model: AHB-Lite single word master writing the DDS control words
`timescale 1ns/1ps
`include "dds_map.svh"
module dds_host_model (
  input  wire logic        core_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic      [11:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [31:0] hwdata_o
);
  initial {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk_i);
    {hsel_o, htrans_o, hwrite_o, haddr_o} <= {1'b1, 2'h2, wr, a};
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    {hsel_o, htrans_o} <= 3'h0;
    hwdata_o <= wd;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
    // Released data bus shows the inverse, never a stale copy
    hwdata_o <= ~wd;
  endtask
  task automatic set_ctrl(input logic [31:0] v);
    logic [31:0] d;
    d = v;
    if (d[`DDS_CTRL_SQEN_BIT])
      d[`DDS_CTRL_MODE_BIT] = 1'b0;
    xfer(1'b1, `DDS_CTRL_OFS, d, d);
  endtask
  task automatic start_up;
    set_ctrl(32'h1 << `DDS_CTRL_RESET_BIT);
  endtask
endmodule // dds_host_model

// ==== verif/dds_output_control_tb_top.sv ====
// Bench top: host model on the bus, DDS outputs checked per scenario
`timescale 1ns/1ps
`include "dds_map.svh"
module dds_output_control_tb_top;
  localparam logic [31:0] RS = 32'h100, HL = 32'h80, PD = 32'h40, SQ = 32'h20;
  localparam logic [31:0] HV = 32'h8, MD = 32'h2, FS = 32'h800, PS = 32'h400;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel, hwrite, hready, dac_en, pin, sqm;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [9:0]  dac, smp;
  int          n_errors = 0, checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  dds_host_model host_u (.core_clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  dds_output_control dut_u (.core_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .dac_data_o(dac),
    .dac_enable_o(dac_en), .waveform_output_pin_o(pin), .square_mode_o(sqm));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_in(input string nm, input logic [31:0] lo, hi, got);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_errors++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, rd);
    chk(nm, exp, rd);
  endtask
  // Waits cover the output pipeline with margin; no done flag exists
  task automatic ctl(input logic [31:0] v, input int k);
    host_u.set_ctrl(v);
    repeat (k) @(negedge clk);
  endtask
  task automatic edges(output int e);
    logic p;
    e = 0;
    p = pin;
    repeat (64)
    begin
      @(negedge clk);
      e += int'(pin !== p);
      p = pin;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("dac_rst", 32'h200, {22'h0, dac});
    chk("dac_en_rst", 32'h1, {31'h0, dac_en});
    rdc("ctrl_rst", `DDS_CTRL_OFS, `DDS_CTRL_RST_VAL);
    host_u.start_up();
    host_u.xfer(1'b1, `DDS_FREQ_A_OFS, 32'h0, rd);
    host_u.xfer(1'b1, `DDS_FREQ_B_OFS, 32'h100_0000, rd);
    host_u.xfer(1'b1, `DDS_PHASE_A_OFS, 32'h0, rd);
    host_u.xfer(1'b1, `DDS_PHASE_B_OFS, 32'h400, rd);
    host_u.set_ctrl(PS);
    n = 0;
    repeat (20)
    begin
      @(negedge clk);
      if (dac !== 10'h200)
        break;
      n++;
    end
    chk_in("resume_delay", 32'h8, 32'h9, n);
    chk_in("sine_peak", 32'h3E0, 32'h3FF, {22'h0, dac});
    ctl(HV, 16);
    chk_in("sine_zero", 32'h1FF, 32'h201, {22'h0, dac});
    ctl(MD | HV, 16);
    chk_in("tri_zero", 32'h0, 32'h1, {22'h0, dac});
    ctl(MD | PS, 16);
    chk_in("tri_quarter", 32'h1FE, 32'h201, {22'h0, dac});
    ctl(FS, 16);
    smp = dac;
    repeat (3) @(negedge clk);
    chk("fsk_moves", 32'h1, {31'h0, dac !== smp});
    ctl(FS | HL, 4);
    smp = dac;
    host_u.xfer(1'b1, `DDS_PHASE_A_OFS, 32'h400, rd);
    ctl(FS | HL | PS, 8);
    chk("halt_hold", {22'h0, smp}, {22'h0, dac});
    rdc("phase_in_halt", `DDS_PHASE_A_OFS, 32'h400);
    ctl(FS, 16);
    smp = dac;
    repeat (3) @(negedge clk);
    chk("halt_release", 32'h1, {31'h0, dac !== smp});
    ctl(FS | RS, 4);
    chk("dac_reset", 32'h200, {22'h0, dac});
    rdc("freq_kept", `DDS_FREQ_B_OFS, 32'h100_0000);
    rdc("ctrl_kept", `DDS_CTRL_OFS, FS | RS);
    ctl(32'h0, 16);
    chk_in("phase_a_peak", 32'h3E0, 32'h3FF, {22'h0, dac});
    ctl(FS | SQ | HV | PD | MD, 16);
    chk("dac_off", 32'h0, {31'h0, dac_en});
    chk("sq_flag", 32'h1, {31'h0, sqm});
    edges(n);
    chk("sq_direct", 32'h8, n);
    ctl(FS | SQ | PD, 16);
    edges(n);
    chk("sq_halved", 32'h4, n);
    ctl(HL | PD, 4);
    chk("dac_off_halt", 32'h0, {31'h0, dac_en});
    rdc("gap_read", 12'h01C, 32'h0);
    complete_run();
  end
endmodule // dds_output_control_tb_top
